// [timer8_pkg.sv]
// Constants, mode codes and shared decoding for the 8-bit waveform timer.
// Assumes a single clock domain; every consumer imports the whole package.
// Contract
// - Normal mode counts up, wraps FF to 00
// - Normal mode overflow flag set at zero
// - Mode 2 clears counter on compare A
// - Clear-on-compare compare A written directly, unbuffered
// - Clear-on-compare action 1 toggles output on match
// - Compare A zero toggles every tick
// - Clear-on-compare overflow flag set at MAX wrap
// - Modes 3/7 single slope, TOP FF or A
// - Fast mode clears one tick after TOP
// - Fast actions: 2 clear/set, 3 set/clear
// - Fast mode overflow flag set at TOP
// - Fast extremes: spike at BOTTOM, constant at MAX
// - Fast action 1 toggles, compare stays buffered
// - Modes 1/5 count dual slope up, down
// - Phase mode holds TOP exactly one tick
// - Phase actions: up-match and down-match levels
// - Phase mode overflow flag set at BOTTOM
// - Phase extremes: BOTTOM low, MAX high
// - Phase output takes up level at BOTTOM only when compare is zero, was MAX or missed
// - Output actions never change counting sequence
// - Pin driven only when direction selects output
// - Compare flag set next tick, cleared by one
// - PWM compare writes buffered, copied at TOP
// - Counter write blocks matches for next tick
`default_nettype none

package timer8_pkg;

   localparam int         CNT_W         = 8;
   localparam logic [7:0] CNT_BOTTOM    = 8'h00;
   localparam logic [7:0] CNT_MAX       = 8'hFF;
   localparam logic [7:0] CNT_ONE       = 8'h01;
   localparam logic [7:0] CMP_RESET     = 8'h00;

   localparam logic [2:0] MODE_NORMAL   = 3'h0;
   localparam logic [2:0] MODE_PHASE_FF = 3'h1;
   localparam logic [2:0] MODE_CLEAR    = 3'h2;
   localparam logic [2:0] MODE_FAST_FF  = 3'h3;
   localparam logic [2:0] MODE_PHASE_A  = 3'h5;
   localparam logic [2:0] MODE_FAST_A   = 3'h7;

   localparam logic [1:0] ACT_NONE      = 2'h0;
   localparam logic [1:0] ACT_TOGGLE    = 2'h1;
   localparam logic [1:0] ACT_CLEAR     = 2'h2;
   localparam logic [1:0] ACT_SET       = 2'h3;

   typedef enum logic [3:0] {
      K_NORMAL = 4'b0001,
      K_CLEAR  = 4'b0010,
      K_FAST   = 4'b0100,
      K_PHASE  = 4'b1000
   } kind_t;

   // Reserved mode codes fall back to plain up-counting.
   function automatic kind_t decode_kind(input logic [2:0] m);
      case (m)
         MODE_NORMAL:                 decode_kind = K_NORMAL;
         MODE_CLEAR:                  decode_kind = K_CLEAR;
         MODE_FAST_FF, MODE_FAST_A:   decode_kind = K_FAST;
         MODE_PHASE_FF, MODE_PHASE_A: decode_kind = K_PHASE;
         default:                     decode_kind = K_NORMAL;
      endcase
   endfunction

   function automatic logic top_from_a(input logic [2:0] m);
      top_from_a = (m == MODE_FAST_A) || (m == MODE_PHASE_A);
   endfunction

endpackage

`default_nettype wire

// [ch_compare.sv]
// One compare channel: compare register with its PWM buffer, match and flag.
// Assumes timer_tick is a one-cycle enable on clk_sys.
`default_nettype none

module ch_compare
   import timer8_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       resetn,
   input  wire logic       timer_tick,
   input  wire logic       buffered,
   input  wire logic       update,
   input  wire logic       cmp_wr,
   input  wire logic [7:0] cmp_wdata,
   input  wire logic [7:0] cnt,
   input  wire logic       blocked,
   input  wire logic       flag_clr,
   output logic      [7:0] cmp_value,
   output logic            cmp_flag,
   output logic            match
);
   typedef struct packed {
      logic [7:0] act;
      logic [7:0] buffer;
      logic       pend;
      logic       flag;
   } cmp_state_t;

   cmp_state_t st_ff;
   cmp_state_t nxt_st;

   assign match     = timer_tick && !blocked && (cnt == st_ff.act);
   assign cmp_value = st_ff.act;
   assign cmp_flag  = st_ff.flag;

   always_comb begin
      nxt_st = st_ff;
      if (timer_tick && update) begin
         nxt_st.act = st_ff.buffer;
      end
      if (cmp_wr) begin
         nxt_st.buffer = cmp_wdata;
         if (!buffered) begin
            nxt_st.act = cmp_wdata;
         end
      end
      if (timer_tick) begin
         nxt_st.pend = match;
      end
      if (flag_clr) begin
         nxt_st.flag = 1'b0;
      end
      // A set landing on the clear cycle wins so no match is lost.
      if (timer_tick && st_ff.pend) begin
         nxt_st.flag = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         st_ff <= '{act: CMP_RESET, buffer: CMP_RESET, pend: 1'b0, flag: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

endmodule

`default_nettype wire

// [ch_wave.sv]
// Waveform state of one compare channel, stepped by matches and slope events.
// Assumes match, at_top and at_bottom are already qualified by timer_tick.
`default_nettype none

module ch_wave
   import timer8_pkg::*;
(
   input  wire logic         clk_sys,
   input  wire logic         resetn,
   input  wire timer8_pkg::kind_t kind,
   input  wire logic [1:0]   action,
   input  wire logic         match,
   input  wire logic         down,
   input  wire logic         at_top,
   input  wire logic         at_bottom,
   input  wire logic         ocr_is_top,
   input  wire logic         ocr_is_zero,
   input  wire logic         wr_above,
   output logic              wave
);
   typedef struct packed {
      logic wave;
      logic was_max;
      logic missed;
   } wave_state_t;

   wave_state_t st_ff;
   wave_state_t nxt_st;
   logic        lvl_up;

   function automatic logic apply_act(input logic [1:0] a, input logic w);
      case (a)
         ACT_TOGGLE: apply_act = !w;
         ACT_CLEAR:  apply_act = 1'b0;
         ACT_SET:    apply_act = 1'b1;
         default:    apply_act = w;
      endcase
   endfunction

   assign wave   = st_ff.wave;
   assign lvl_up = (action == ACT_SET);

   always_comb begin
      nxt_st = st_ff;
      if (wr_above) begin
         nxt_st.missed = 1'b1;
      end
      case (kind)
         K_FAST: begin
            if (match) begin
               nxt_st.wave = apply_act(action, st_ff.wave);
            end
            // The BOTTOM action wins, which gives the constant level at MAX.
            if (at_top && action[1]) begin
               nxt_st.wave = !lvl_up;
            end
         end
         K_PHASE: begin
            if (match) begin
               if (action == ACT_TOGGLE) begin
                  nxt_st.wave = !st_ff.wave;
               end else if (action[1]) begin
                  nxt_st.wave = (down || at_top) ? !lvl_up : lvl_up;
               end
               if (!down && !at_top) begin
                  nxt_st.missed = 1'b0;
               end
            end
            if (at_top) begin
               nxt_st.was_max = ocr_is_top;
            end
            if (at_bottom) begin
               nxt_st.missed = 1'b0;
               if (action[1] && !ocr_is_top && (ocr_is_zero || st_ff.was_max || st_ff.missed)) begin
                  nxt_st.wave = lvl_up;
               end
            end
         end
         default: begin
            if (match) begin
               nxt_st.wave = apply_act(action, st_ff.wave);
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         st_ff <= '{wave: 1'b0, was_max: 1'b0, missed: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

endmodule

`default_nettype wire

// [timer8_wave.sv]
// Top of the 8-bit waveform timer: counter, overflow flag, two channels, pins.
// Assumes all control ports come from logic on clk_sys and timer_tick is a
// one-cycle prescaler enable; software strobes are one-cycle pulses.
`default_nettype none

module timer8_wave
   import timer8_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       resetn,
   input  wire logic       timer_tick,
   input  wire logic [2:0] wave_mode_sel,
   input  wire logic [1:0] out_action_sel_a,
   input  wire logic [1:0] out_action_sel_b,
   input  wire logic       count_wr,
   input  wire logic [7:0] count_wdata,
   input  wire logic       compare_wr_a,
   input  wire logic       compare_wr_b,
   input  wire logic [7:0] compare_wdata,
   input  wire logic       overflow_clr,
   input  wire logic       compare_clr_a,
   input  wire logic       compare_clr_b,
   input  wire logic       port_data_a,
   input  wire logic       port_data_b,
   input  wire logic       pin_dir_a,
   input  wire logic       pin_dir_b,
   output logic      [7:0] count_value,
   output logic      [7:0] compare_value_a,
   output logic      [7:0] compare_value_b,
   output logic            overflow_flag,
   output logic            compare_flag_a,
   output logic            compare_flag_b,
   output logic            wave_out_a,
   output logic            wave_out_b,
   output logic            pin_out_a,
   output logic            pin_oe_a,
   output logic            pin_out_b,
   output logic            pin_oe_b
);
   import timer8_pkg::*;

   typedef struct packed {
      logic [7:0] cnt;
      logic       down;
      logic       blocked;
      logic       ovf;
      logic [1:0] pin_out;
      logic [1:0] pin_oe;
   } top_state_t;

   top_state_t st_ff;
   top_state_t nxt_st;

   kind_t      kind;
   logic [7:0] top_val;
   logic       at_top;
   logic       at_bottom;
   logic       buffered;
   logic       update;
   logic       fast_wrap;
   logic       phase_bottom;

   logic [1:0] match_w;
   logic [1:0] flag_w;
   logic [1:0] wave_w;
   logic [1:0] cmp_wr_w;
   logic [1:0] cmp_clr_w;
   logic [1:0] act_w [2];
   logic [7:0] cmp_w [2];
   logic [1:0] port_w;
   logic [1:0] dir_w;

   // Only the mode field and compare A steer counting; the action fields never reach it.
   assign kind      = decode_kind(wave_mode_sel);
   assign top_val   = top_from_a(wave_mode_sel) ? cmp_w[0] : CNT_MAX;
   assign at_top    = (st_ff.cnt == top_val);
   assign at_bottom = (st_ff.cnt == CNT_BOTTOM);
   assign buffered  = (kind == K_FAST) || (kind == K_PHASE);
   assign update    = buffered && at_top;

   assign fast_wrap    = timer_tick && (kind == K_FAST) && at_top;
   assign phase_bottom = timer_tick && (kind == K_PHASE) && at_bottom;

   assign cmp_wr_w  = {compare_wr_b, compare_wr_a};
   assign cmp_clr_w = {compare_clr_b, compare_clr_a};
   assign act_w[0]  = out_action_sel_a;
   assign act_w[1]  = out_action_sel_b;
   assign port_w    = {port_data_b, port_data_a};
   assign dir_w     = {pin_dir_b, pin_dir_a};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_ch
         ch_compare u_cmp (
            .clk_sys    (clk_sys),
            .resetn     (resetn),
            .timer_tick (timer_tick),
            .buffered   (buffered),
            .update     (update),
            .cmp_wr     (cmp_wr_w[gi]),
            .cmp_wdata  (compare_wdata),
            .cnt        (st_ff.cnt),
            .blocked    (st_ff.blocked),
            .flag_clr   (cmp_clr_w[gi]),
            .cmp_value  (cmp_w[gi]),
            .cmp_flag   (flag_w[gi]),
            .match      (match_w[gi])
         );

         ch_wave u_wave (
            .clk_sys     (clk_sys),
            .resetn      (resetn),
            .kind        (kind),
            .action      (act_w[gi]),
            .match       (match_w[gi]),
            .down        (st_ff.down),
            .at_top      ((kind == K_FAST) ? fast_wrap : (timer_tick && at_top)),
            .at_bottom   (phase_bottom),
            .ocr_is_top  (cmp_w[gi] == top_val),
            .ocr_is_zero (cmp_w[gi] == CNT_BOTTOM),
            .wr_above    (count_wr && (count_wdata > cmp_w[gi])),
            .wave        (wave_w[gi])
         );
      end
   endgenerate

   always_comb begin
      nxt_st = st_ff;
      // Clearing comes first so that a set in the same cycle wins.
      if (overflow_clr) begin
         nxt_st.ovf = 1'b0;
      end
      if (timer_tick) begin
         nxt_st.blocked = 1'b0;
         case (kind)
            K_CLEAR: begin
               // A compare value below the count is missed until after the wrap.
               if (match_w[0]) begin
                  nxt_st.cnt = CNT_BOTTOM;
               end else begin
                  nxt_st.cnt = 8'(st_ff.cnt + CNT_ONE);
               end
               if (st_ff.cnt == CNT_MAX) begin
                  nxt_st.ovf = 1'b1;
               end
            end
            K_FAST: begin
               if (at_top) begin
                  nxt_st.cnt = CNT_BOTTOM;
                  nxt_st.ovf = 1'b1;
               end else begin
                  nxt_st.cnt = 8'(st_ff.cnt + CNT_ONE);
               end
            end
            K_PHASE: begin
               if (at_bottom) begin
                  nxt_st.ovf = 1'b1;
               end
               // TOP and BOTTOM are each seen for one tick before the turn.
               if (!st_ff.down && at_top && !at_bottom) begin
                  nxt_st.down = 1'b1;
                  nxt_st.cnt  = 8'(st_ff.cnt - CNT_ONE);
               end else if (st_ff.down && !at_bottom) begin
                  nxt_st.cnt = 8'(st_ff.cnt - CNT_ONE);
               end else begin
                  nxt_st.down = 1'b0;
                  nxt_st.cnt  = 8'(st_ff.cnt + CNT_ONE);
               end
            end
            default: begin
               nxt_st.cnt = 8'(st_ff.cnt + CNT_ONE);
               if (st_ff.cnt == CNT_MAX) begin
                  nxt_st.ovf = 1'b1;
               end
            end
         endcase
         if (kind != K_PHASE) begin
            nxt_st.down = 1'b0;
         end
      end
      // A software write beats counting and holds matches off for one tick.
      if (count_wr) begin
         nxt_st.cnt     = count_wdata;
         nxt_st.blocked = 1'b1;
      end
      for (int i = 0; i < 2; i++) begin
         nxt_st.pin_out[i] = (act_w[i] != ACT_NONE) ? wave_w[i] : port_w[i];
         nxt_st.pin_oe[i]  = dir_w[i];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         st_ff <= '{cnt: CNT_BOTTOM, down: 1'b0, blocked: 1'b0, ovf: 1'b0,
                    pin_out: 2'h0, pin_oe: 2'h0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign count_value     = st_ff.cnt;
   assign overflow_flag   = st_ff.ovf;
   assign compare_value_a = cmp_w[0];
   assign compare_value_b = cmp_w[1];
   assign compare_flag_a  = flag_w[0];
   assign compare_flag_b  = flag_w[1];
   assign wave_out_a      = wave_w[0];
   assign wave_out_b      = wave_w[1];
   assign pin_out_a       = st_ff.pin_out[0];
   assign pin_oe_a        = st_ff.pin_oe[0];
   assign pin_out_b       = st_ff.pin_out[1];
   assign pin_oe_b        = st_ff.pin_oe[1];

   // Helper for the turn check at TOP.
   logic [7:0] top_less;
   assign top_less = 8'(top_val - CNT_ONE);

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   normal_wrap_a: assert property (
      timer_tick && !count_wr && kind == K_NORMAL && count_value == CNT_MAX
      |=> count_value == CNT_BOTTOM)
      else $error("normal mode did not wrap to zero");

   normal_ovf_a: assert property (
      timer_tick && !count_wr && kind == K_NORMAL && count_value == CNT_MAX
      |=> overflow_flag && count_value == CNT_BOTTOM)
      else $error("overflow flag not set with zero count");

   clear_match_a: assert property (
      timer_tick && !count_wr && kind == K_CLEAR && count_value == compare_value_a && !st_ff.blocked
      |=> count_value == CNT_BOTTOM)
      else $error("counter not cleared on compare A match");

   fast_wrap_a: assert property (
      timer_tick && !count_wr && kind == K_FAST && at_top
      |=> count_value == CNT_BOTTOM && overflow_flag)
      else $error("fast mode did not restart after top");

   phase_turn_a: assert property (
      timer_tick && !count_wr && kind == K_PHASE && !st_ff.down && at_top && !at_bottom
      |=> st_ff.down && count_value == $past(top_less))
      else $error("phase mode did not turn after one tick at top");

   phase_ovf_a: assert property (
      timer_tick && kind == K_PHASE && at_bottom |=> overflow_flag)
      else $error("overflow flag missing at bottom");

   write_block_a: assert property (
      st_ff.blocked && timer_tick |-> match_w == 2'h0)
      else $error("match seen in tick after counter write");

   flag_delay_a: assert property (
      match_w[0] ##1 (timer_tick && !compare_clr_a)[*1] |=> compare_flag_a)
      else $error("compare flag not set on tick after match");

   pin_gate_a: assert property (
      !pin_dir_a |=> !pin_oe_a)
      else $error("pin driven while direction is input");

   clear_toggle_a: assert property (
      kind == K_CLEAR && out_action_sel_a == ACT_TOGGLE && match_w[0]
      |=> wave_out_a != $past(wave_out_a))
      else $error("toggle action did not flip output");

   clear_ovf_a: assert property (
      timer_tick && !count_wr && kind == K_CLEAR && count_value == CNT_MAX
      |=> overflow_flag)
      else $error("overflow flag missing after max in clear mode");

   fast_count_a: assert property (
      timer_tick && !count_wr && kind == K_FAST && !at_top
      |=> count_value == 8'($past(count_value) + CNT_ONE))
      else $error("fast mode did not count up below top");

   phase_down_a: assert property (
      timer_tick && !count_wr && kind == K_PHASE && st_ff.down && !at_bottom
      |=> st_ff.down && count_value == 8'($past(count_value) - CNT_ONE))
      else $error("phase mode did not count down");

   phase_up_a: assert property (
      timer_tick && !count_wr && kind == K_PHASE && !st_ff.down && !at_top
      |=> !st_ff.down && count_value == 8'($past(count_value) + CNT_ONE))
      else $error("phase mode did not count up");

   buf_hold_a: assert property (
      (kind == K_FAST || kind == K_PHASE) && !(timer_tick && at_top)
      |=> $stable(compare_value_a) && $stable(compare_value_b))
      else $error("buffered compare value changed away from top");

   direct_wr_a: assert property (
      kind == K_CLEAR && compare_wr_a |=> compare_value_a == $past(compare_wdata))
      else $error("compare write did not take effect directly");

   fast_bottom_a: assert property (
      fast_wrap && out_action_sel_b == ACT_CLEAR |=> wave_out_b)
      else $error("fast output not set at bottom");

   phase_up_clr_a: assert property (
      kind == K_PHASE && out_action_sel_b == ACT_CLEAR && match_w[1] && !st_ff.down && !at_top
      |=> !wave_out_b)
      else $error("phase output not cleared on up match");

   pin_oe_b_a: assert property (
      pin_dir_b |=> pin_oe_b)
      else $error("pin B not enabled after direction set");

   pin_src_a: assert property (
      out_action_sel_a != ACT_NONE |=> pin_out_a == $past(wave_out_a))
      else $error("pin A does not follow the waveform");

   ovf_hold_a: assert property (
      overflow_flag && !overflow_clr |=> overflow_flag)
      else $error("overflow flag dropped without a clear");

   flag_hold_a: assert property (
      compare_flag_b && !compare_clr_b |=> compare_flag_b)
      else $error("compare flag dropped without a clear");

   normal_wrap_c: cover property (
      timer_tick && kind == K_NORMAL && count_value == CNT_MAX);
   clear_match_c: cover property (
      kind == K_CLEAR && match_w[0] ##1 count_value == CNT_BOTTOM);
   phase_turn_c: cover property (
      kind == K_PHASE && timer_tick && at_top ##1 st_ff.down);
   fast_pwm_c: cover property (
      kind == K_FAST && out_action_sel_a == ACT_CLEAR && match_w[0] ##1 !wave_out_a);

endmodule

`default_nettype wire

// [timer8_pin_model.sv]
// Load model of one timer output pin: resolves the pad level seen outside.
// Assumes pin_out and pin_oe are registered outputs on clk_sys.
`default_nettype none

module timer8_pin_model (
   input  wire logic clk_sys,
   input  wire logic pin_out,
   input  wire logic pin_oe,
   output logic      pad
);
   timeunit 1ns;
   timeprecision 1ps;

   logic float_ff = 1'b0;

   // The pad has no pull, so a released pad wanders every cycle instead of
   // keeping the last driven level, which would hide a missing enable.
   always_ff @(posedge clk_sys) begin
      float_ff <= pin_oe ? ~pin_out : ~float_ff;
   end

   assign pad = pin_oe ? pin_out : float_ff;

endmodule

`default_nettype wire

// [timer8_wave_tb_top.sv]
// Self-checking bench for the 8-bit waveform timer and its pins.
// Assumes the package, the timer, its channels and the pin model come first.
`default_nettype none

module timer8_wave_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import timer8_pkg::*;

   logic       clk_sys = 1'b0, resetn = 1'b0, timer_tick = 1'b0;
   logic [2:0] wave_mode_sel = 3'h0;
   logic [1:0] out_action_sel_a = 2'h0, out_action_sel_b = 2'h0;
   logic       count_wr = 1'b0, compare_wr_a = 1'b0, compare_wr_b = 1'b0;
   logic [7:0] count_wdata = 8'h00, compare_wdata = 8'h00;
   logic       overflow_clr = 1'b0, compare_clr_a = 1'b0, compare_clr_b = 1'b0;
   logic       port_data_a = 1'b0, port_data_b = 1'b0, pin_dir_a = 1'b0, pin_dir_b = 1'b0;
   logic [7:0] count_value, compare_value_a, compare_value_b, v, got;
   logic       overflow_flag, compare_flag_a, compare_flag_b, wave_out_a, wave_out_b;
   logic       pin_out_a, pin_oe_a, pin_out_b, pin_oe_b, pad_a, pad_b;
   logic [11:0] chk_q [$];
   logic [11:0] e;
   int         error_cnt = 0, n_tests = 0, cyc = 0, i;
   int         seed = 32'h636E0783;

   timer8_wave u_dut (.clk_sys, .resetn, .timer_tick, .wave_mode_sel, .out_action_sel_a,
      .out_action_sel_b, .count_wr, .count_wdata, .compare_wr_a, .compare_wr_b, .compare_wdata,
      .overflow_clr, .compare_clr_a, .compare_clr_b, .port_data_a, .port_data_b, .pin_dir_a,
      .pin_dir_b, .count_value, .compare_value_a, .compare_value_b, .overflow_flag,
      .compare_flag_a, .compare_flag_b, .wave_out_a, .wave_out_b, .pin_out_a, .pin_oe_a,
      .pin_out_b, .pin_oe_b);
   timer8_pin_model u_pin_a (.clk_sys, .pin_out(pin_out_a), .pin_oe(pin_oe_a), .pad(pad_a));
   timer8_pin_model u_pin_b (.clk_sys, .pin_out(pin_out_b), .pin_oe(pin_oe_b), .pad(pad_b));

   initial begin
      forever #4 clk_sys = ~clk_sys;
   end

   function automatic logic [7:0] pick(input logic [3:0] s);
      case (s)
         4'h0:    pick = count_value;
         4'h1:    pick = {7'h00, overflow_flag};
         4'h2:    pick = {7'h00, compare_flag_a};
         4'h3:    pick = compare_value_a;
         4'h4:    pick = compare_value_b;
         4'h5:    pick = {7'h00, wave_out_a};
         4'h6:    pick = {7'h00, wave_out_b};
         4'h7:    pick = {7'h00, pad_a};
         4'h8:    pick = {7'h00, pin_oe_a};
         4'h9:    pick = {7'h00, compare_flag_b};
         4'hA:    pick = {7'h00, pad_b};
         default: pick = {7'h00, pin_oe_b};
      endcase
   endfunction

   task automatic ex(input logic [3:0] s, input logic [7:0] x);
      chk_q.push_back({s, x});
   endtask

   task automatic run(input int n);
      @(posedge clk_sys);
      timer_tick <= 1'b1;
      repeat (n) @(posedge clk_sys);
      timer_tick <= 1'b0;
      @(negedge clk_sys);
   endtask

   task automatic wr_cnt(input logic [7:0] x);
      @(posedge clk_sys);
      count_wr    <= 1'b1;
      count_wdata <= x;
      @(posedge clk_sys);
      count_wr <= 1'b0;
      @(negedge clk_sys);
   endtask

   task automatic wr_cmp(input logic b, input logic [7:0] x);
      @(posedge clk_sys);
      compare_wr_a  <= ~b;
      compare_wr_b  <= b;
      compare_wdata <= x;
      @(posedge clk_sys);
      compare_wr_a <= 1'b0;
      compare_wr_b <= 1'b0;
      @(posedge clk_sys);
      @(negedge clk_sys);
   endtask

   task automatic clr_flags;
      @(posedge clk_sys);
      {overflow_clr, compare_clr_a, compare_clr_b} <= 3'h7;
      @(posedge clk_sys);
      {overflow_clr, compare_clr_a, compare_clr_b} <= 3'h0;
      @(negedge clk_sys);
   endtask

   task automatic done(input string name);
      @(negedge clk_sys);
      @(negedge clk_sys);
      $display("test %s done", name);
   endtask

   task automatic tally_and_finish;
      $display("checks %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Results are compared just after the falling edge, well clear of updates.
   initial begin
      forever begin
         @(negedge clk_sys);
         #1;
         while (chk_q.size() > 0) begin
            e   = chk_q.pop_front();
            got = pick(e[11:8]);
            n_tests++;
            if (got !== e[7:0]) begin
               error_cnt++;
               $display("[ERR] t=%0t sel=%0d got=%h exp=%h", $time, e[11:8], got, e[7:0]);
            end
         end
      end
   end

   // The whole sequence needs well under a thousand cycles.
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         tally_and_finish();
      end
   end

   initial begin
      repeat (20) @(posedge clk_sys);
      resetn <= 1'b1;
      @(negedge clk_sys);
      ex(4'h0, 8'h00);
      ex(4'h1, 8'h00);
      ex(4'h3, 8'h00);
      ex(4'h8, 8'h00);
      for (i = 0; i < 4; i++) begin
         v = 8'($random(seed));
         @(posedge clk_sys);
         port_data_a <= v[7];
         pin_dir_a   <= 1'b1;
         wr_cnt(v);
         run(1);
         ex(4'h0, v + 8'h01);
         ex(4'h7, {7'h00, v[7]});
      end
      clr_flags();
      wr_cnt(8'hFE);
      run(1);
      ex(4'h0, 8'hFF);
      ex(4'h1, 8'h00);
      run(1);
      ex(4'h0, 8'h00);
      ex(4'h1, 8'h01);
      clr_flags();
      ex(4'h1, 8'h00);
      @(posedge clk_sys);
      wave_mode_sel <= MODE_FAST_FF;
      wr_cnt(8'hFE);
      run(2);
      ex(4'h0, 8'h00);
      ex(4'h1, 8'h01);
      done("normal");
      @(posedge clk_sys);
      wave_mode_sel <= MODE_CLEAR;
      wr_cmp(1'b0, 8'h05);
      ex(4'h3, 8'h05);
      wr_cnt(8'h05);
      run(1);
      ex(4'h0, 8'h06);
      run(1);
      clr_flags();
      run(248);
      ex(4'h0, 8'hFF);
      ex(4'h1, 8'h00);
      run(1);
      ex(4'h0, 8'h00);
      ex(4'h1, 8'h01);
      clr_flags();
      run(6);
      ex(4'h0, 8'h00);
      ex(4'h1, 8'h00);
      run(1);
      ex(4'h2, 8'h01);
      clr_flags();
      ex(4'h2, 8'h00);
      run(5);
      wr_cmp(1'b0, 8'h00);
      @(posedge clk_sys);
      out_action_sel_a <= ACT_TOGGLE;
      run(1);
      ex(4'h5, 8'h01);
      run(1);
      ex(4'h5, 8'h00);
      ex(4'h0, 8'h00);
      run(1);
      done("toggle");
      ex(4'h7, 8'h01);
      @(posedge clk_sys);
      pin_dir_a <= 1'b0;
      done("pin");
      ex(4'h8, 8'h00);
      @(posedge clk_sys);
      wave_mode_sel    <= MODE_FAST_A;
      out_action_sel_a <= ACT_SET;
      wr_cmp(1'b0, 8'h0A);
      ex(4'h3, 8'h00);
      run(1);
      ex(4'h3, 8'h0A);
      @(posedge clk_sys);
      out_action_sel_b <= ACT_CLEAR;
      wr_cmp(1'b1, 8'h04);
      clr_flags();
      run(10);
      ex(4'h0, 8'h0A);
      ex(4'h1, 8'h00);
      run(1);
      ex(4'h0, 8'h00);
      ex(4'h1, 8'h01);
      ex(4'h4, 8'h04);
      ex(4'h9, 8'h01);
      ex(4'h6, 8'h01);
      for (i = 0; i < 3; i++) begin
         @(posedge clk_sys);
         out_action_sel_b <= (i == 0) ? ACT_CLEAR : (i == 1) ? ACT_SET : ACT_TOGGLE;
         run(5);
         ex(4'h6, {7'h00, 1'(3'b110 >> i)});
         run(6);
         ex(4'h6, {7'h00, 1'(3'b101 >> i)});
      end
      ex(4'h5, 8'h00);
      done("fast");
      @(posedge clk_sys);
      wave_mode_sel    <= MODE_PHASE_A;
      out_action_sel_b <= ACT_CLEAR;
      pin_dir_b        <= 1'b1;
      run(10);
      ex(4'h0, 8'h0A);
      ex(4'h6, 8'h00);
      ex(4'hA, 8'h00);
      clr_flags();
      run(1);
      ex(4'h0, 8'h09);
      run(9);
      ex(4'h0, 8'h00);
      ex(4'h1, 8'h00);
      ex(4'h6, 8'h01);
      ex(4'hA, 8'h01);
      run(1);
      ex(4'h0, 8'h01);
      ex(4'h1, 8'h01);
      @(posedge clk_sys);
      wave_mode_sel <= MODE_PHASE_FF;
      wr_cnt(8'hFE);
      run(2);
      ex(4'h0, 8'hFE);
      done("phase");
      tally_and_finish();
   end

endmodule

`default_nettype wire
